// [rtl/wdt_ctrl_pkg.sv]
// shared constants for the counter array watchdog and control block
package wdt_ctrl_pkg;
    // register addresses on the special function register port
    localparam logic [7:0] ADDR_CTRL   = 8'hD8;
    localparam logic [7:0] ADDR_MODE   = 8'hD9;
    localparam logic [7:0] ADDR_CNT_LO = 8'hF9;
    localparam logic [7:0] ADDR_CNT_HI = 8'hFA;
    localparam logic [7:0] ADDR_M5_OFS = 8'hFD;
    localparam logic [7:0] ADDR_M5_UPD = 8'hFE;

    // control register fields
    localparam int CTRL_OVF_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_M5_BIT  = 5;

    // mode register fields
    localparam int MODE_IDLE_BIT = 7;
    localparam int MODE_WATCHDOG_ENABLE_BIT_BIT = 6;
    localparam int MODE_LOCK_BIT = 5;
    localparam int MODE_CPS_LSB  = 1;
    localparam int MODE_CPS_MSB  = 3;
    localparam int MODE_ECF_BIT  = 0;

    // reset values and last counter values
    localparam logic [5:0]  MATCH_RESET = 6'h00;
    localparam logic [15:0] CNT_RESET   = 16'h0000;
    localparam logic [7:0]  OFS_RESET   = 8'h00;
    localparam logic [7:0]  UPD_RESET   = 8'h00;
    localparam logic [15:0] CNT_LAST    = 16'hFFFF;
    localparam logic [7:0]  LOW_LAST    = 8'hFF;

    // timebase select codes
    localparam logic [2:0] CPS_DIV12 = 3'h0;
    localparam logic [2:0] CPS_DIV4  = 3'h1;
    localparam logic [2:0] CPS_T0    = 3'h2;
    localparam logic [2:0] CPS_ECI   = 3'h3;
    localparam logic [2:0] CPS_SYS   = 3'h4;
    localparam logic [2:0] CPS_EXT8  = 3'h5;

    // divider figures and module count
    localparam int SYSTEM_CLOCK_DIV_SLOW = 12;
    localparam int SYSTEM_CLOCK_DIV_FAST = 4;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;
    localparam int NUM_MODULES = 6;
endpackage

// [rtl/counter_timebase.sv]
// timebase tick generator for the counter array
`timescale 1ns/100ps
module counter_timebase
    import wdt_ctrl_pkg::*;
#(
    parameter int SLOW_DIV = SYSTEM_CLOCK_DIV_SLOW
) (
    input  wire logic       i_clk,     // system clock
    input  wire logic       i_reset,   // synchronous, active high
    input  wire logic [2:0] i_sel,     // timebase select code
    input  wire logic       i_t0_ovf,  // timer 0 overflow pulse
    input  wire logic       i_eci,     // external count pin
    input  wire logic       i_ext_clk, // external clock pin
    output logic            o_tick     // one counter step
);
    localparam int DW = $clog2(SLOW_DIV);

    // the fast tick is taken from the slow divider, so it must divide it
    if ((SLOW_DIV % SYSTEM_CLOCK_DIV_FAST) != 0 || SLOW_DIV < SYSTEM_CLOCK_DIV_FAST) begin : g_bad_div
        $error("SLOW_DIV must be a multiple of the fast divider");
    end

    logic [DW-1:0] div_r, div_nxt;
    logic          eci_s1_r, eci_s2_r, eci_s3_r;
    logic          ext_s1_r, ext_s2_r, ext_s3_r;
    logic [2:0]    ext_cnt_r, ext_cnt_nxt;
    logic          tick_nxt;
    logic          slow, fast, eci_fall, ext_rise;

    // divider and tick selection
    always_comb begin
        slow        = (div_r == DW'(SLOW_DIV - 1));
        fast        = ((div_r % DW'(SYSTEM_CLOCK_DIV_FAST)) == DW'(SYSTEM_CLOCK_DIV_FAST - 1));
        div_nxt     = slow ? '0 : div_r + DW'(1);
        eci_fall    = eci_s3_r & ~eci_s2_r;
        ext_rise    = ext_s2_r & ~ext_s3_r;
        ext_cnt_nxt = ext_cnt_r + {2'h0, ext_rise};
        case (i_sel)
            CPS_DIV12: tick_nxt = slow;
            CPS_DIV4:  tick_nxt = fast;
            CPS_T0:    tick_nxt = i_t0_ovf;
            CPS_ECI:   tick_nxt = eci_fall;
            CPS_SYS:   tick_nxt = 1'b1;
            CPS_EXT8:  tick_nxt = ext_rise & (ext_cnt_r == EXT_DIV_LAST);
            default:   tick_nxt = 1'b0; // reserved codes stop the count
        endcase
    end

    // pins pass two flops before the edge detectors look at them
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_r     <= '0;
            eci_s1_r  <= 1'b1;
            eci_s2_r  <= 1'b1;
            eci_s3_r  <= 1'b1;
            ext_s1_r  <= 1'b0;
            ext_s2_r  <= 1'b0;
            ext_s3_r  <= 1'b0;
            ext_cnt_r <= 3'h0;
            o_tick    <= 1'b0;
        end else begin
            div_r     <= div_nxt;
            eci_s1_r  <= i_eci;
            eci_s2_r  <= eci_s1_r;
            eci_s3_r  <= eci_s2_r;
            ext_s1_r  <= i_ext_clk;
            ext_s2_r  <= ext_s1_r;
            ext_s3_r  <= ext_s2_r;
            ext_cnt_r <= ext_cnt_nxt;
            o_tick    <= tick_nxt;
        end
    end

    // helper: gap since last tick while the slow code stays selected
    // a tick launched under the previous code must not start the spacing count
    logic [7:0] gap_r;
    logic       steady_r;
    logic       sel_slow_r;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            gap_r      <= 8'h00;
            steady_r   <= 1'b0;
            sel_slow_r <= 1'b0;
        end else begin
            gap_r      <= o_tick ? 8'h00 : gap_r + 8'h01;
            sel_slow_r <= (i_sel == CPS_DIV12);
            steady_r   <= (i_sel == CPS_DIV12) && sel_slow_r && (o_tick || steady_r);
        end
    end

    a_div12_gap: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_tick && steady_r && i_sel == CPS_DIV12) |-> gap_r == 8'(SLOW_DIV - 1))
        else $error("slow timebase tick spacing wrong");
endmodule // counter_timebase

// [rtl/counter_array_watchdog.sv]
// counter array control register, 16-bit counter and module 5 watchdog
`timescale 1ns/100ps
module counter_array_watchdog
    import wdt_ctrl_pkg::*;
#(
    parameter int SLOW_DIV = SYSTEM_CLOCK_DIV_SLOW
) (
    input  wire logic        I_CLK,        // system clock, 20 MHz
    input  wire logic        I_RESET,      // synchronous, active high
    input  wire logic [7:0]  I_SFR_ADDR,   // register address
    input  wire logic        I_SFR_WR,     // byte write strobe
    input  wire logic        I_SFR_RD,     // read strobe
    input  wire logic [7:0]  I_SFR_WDATA,  // byte write data
    input  wire logic        I_BIT_WR,     // control register bit write
    input  wire logic [2:0]  I_BIT_IDX,    // bit number for bit write
    input  wire logic        I_BIT_VAL,    // bit value for bit write
    input  wire logic        I_IDLE,       // cpu idle mode level
    input  wire logic        I_T0_OVF,     // timer 0 overflow pulse
    input  wire logic        I_ECI,        // external count pin
    input  wire logic        I_EXT_CLK,    // external clock pin
    input  wire logic [5:0]  I_MATCH_EVT,  // per-module match/capture pulse
    input  wire logic [5:0]  I_MATCH_IE,   // per-module interrupt enables
    output logic      [7:0]  O_SFR_RDATA,  // read data, one cycle after read
    output logic      [15:0] O_COUNT,      // counter value
    output logic             O_IRQ,        // shared interrupt request
    output logic             O_WDT_RESET,  // watchdog reset pulse
    output logic             O_WDT_ACTIVE  // watchdog enabled
);
    // byte-write decode, shared by every register
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
        wr_hit = I_SFR_WR && (a == target);
    endfunction

    logic        tick;
    logic        cf_r, cf_nxt, cr_r, cr_nxt;
    logic [5:0]  ccf_r, ccf_nxt;
    logic        idle_suspend_select_r, idle_suspend_select_nxt, watchdog_enable_bit_r, watchdog_enable_bit_nxt, lock_r, lock_nxt, ecf_r, ecf_nxt;
    logic [2:0]  cps_r, cps_nxt;
    logic [7:0]  ofs_r, ofs_nxt, upd_r, upd_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0]  rdata_nxt, ctrl_cur, ctrl_new, cnt_hi;
    logic        irq_nxt, wrst_nxt, act_nxt;
    logic        wd_en, step, wrap, low_ovf, m5_one_wr, expire, ctrl_wr;

    counter_timebase #(
        .SLOW_DIV (SLOW_DIV)
    ) u_timebase (
        .i_clk     (I_CLK),
        .i_reset   (I_RESET),
        .i_sel     (cps_r),
        .i_t0_ovf  (I_T0_OVF),
        .i_eci     (I_ECI),
        .i_ext_clk (I_EXT_CLK),
        .o_tick    (tick)
    );

    // counter, flags, mode and watchdog next state
    always_comb begin
        wd_en    = watchdog_enable_bit_r | lock_r;
        step     = tick & (cr_r | wd_en) & ~(idle_suspend_select_r & I_IDLE);
        cnt_hi   = cnt_r[15:8];
        wrap     = step & (cnt_r == CNT_LAST);
        low_ovf  = step & (cnt_r[7:0] == LOW_LAST);
        ctrl_cur = {cf_r, cr_r, ccf_r};
        ctrl_wr  = wr_hit(I_SFR_ADDR, ADDR_CTRL);
        ctrl_new = ctrl_wr ? I_SFR_WDATA : ctrl_cur;
        if (I_BIT_WR) begin
            ctrl_new[I_BIT_IDX] = I_BIT_VAL;
        end
        m5_one_wr = (ctrl_wr && I_SFR_WDATA[CTRL_M5_BIT])
                  || (I_BIT_WR && I_BIT_IDX == 3'(CTRL_M5_BIT) && I_BIT_VAL);
        // hardware set wins over a software clear in the same cycle
        cf_nxt  = ctrl_new[CTRL_OVF_BIT] | wrap;
        cr_nxt  = ctrl_new[CTRL_RUN_BIT];
        ccf_nxt = ctrl_new[5:0] | I_MATCH_EVT;

        // counter bytes cannot be written while the watchdog owns them
        cnt_nxt = step ? cnt_r + 16'h0001 : cnt_r;
        if (!wd_en && wr_hit(I_SFR_ADDR, ADDR_CNT_LO)) begin
            cnt_nxt[7:0] = I_SFR_WDATA;
        end
        if (!wd_en && wr_hit(I_SFR_ADDR, ADDR_CNT_HI)) begin
            cnt_nxt[15:8] = I_SFR_WDATA;
        end

        idle_suspend_select_nxt = idle_suspend_select_r;
        cps_nxt  = cps_r;
        ecf_nxt  = ecf_r;
        watchdog_enable_bit_nxt = watchdog_enable_bit_r;
        lock_nxt = lock_r;
        if (wr_hit(I_SFR_ADDR, ADDR_MODE)) begin
            lock_nxt = lock_r | I_SFR_WDATA[MODE_LOCK_BIT];
            if (!lock_r) begin
                watchdog_enable_bit_nxt = I_SFR_WDATA[MODE_WATCHDOG_ENABLE_BIT_BIT];
            end
            // judged on the state before the write: one write cannot disable and retune
            if (!wd_en) begin
                idle_suspend_select_nxt = I_SFR_WDATA[MODE_IDLE_BIT];
                cps_nxt  = I_SFR_WDATA[MODE_CPS_MSB:MODE_CPS_LSB];
                ecf_nxt  = I_SFR_WDATA[MODE_ECF_BIT];
            end
        end
        act_nxt = watchdog_enable_bit_nxt | lock_nxt;

        ofs_nxt = wr_hit(I_SFR_ADDR, ADDR_M5_OFS) ? I_SFR_WDATA : ofs_r;
        upd_nxt = wr_hit(I_SFR_ADDR, ADDR_M5_UPD) ? 8'(cnt_hi + ofs_r) : upd_r;

        expire   = wd_en & low_ovf & (upd_r == cnt_hi);
        // one pulse only; the reset controller then resets this block
        wrst_nxt = (expire | (wd_en & m5_one_wr)) & ~O_WDT_RESET;
        irq_nxt  = (cf_r & ecf_r) | (|(ccf_r & I_MATCH_IE));
    end

    // read data mux, held between reads
    always_comb begin
        rdata_nxt = O_SFR_RDATA;
        if (I_SFR_RD) begin
            case (I_SFR_ADDR)
                ADDR_CTRL:   rdata_nxt = ctrl_cur;
                ADDR_MODE:   rdata_nxt = {idle_suspend_select_r, watchdog_enable_bit_r, lock_r, 1'b0, cps_r, ecf_r};
                ADDR_CNT_LO: rdata_nxt = cnt_r[7:0];
                ADDR_CNT_HI: rdata_nxt = cnt_hi;
                ADDR_M5_OFS: rdata_nxt = ofs_r;
                ADDR_M5_UPD: rdata_nxt = upd_r;
                default:     rdata_nxt = 8'h00;
            endcase
        end
    end

    // registers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            cf_r         <= 1'b0;
            cr_r         <= 1'b0;
            ccf_r        <= MATCH_RESET;
            idle_suspend_select_r       <= 1'b0;
            watchdog_enable_bit_r       <= 1'b1;
            lock_r       <= 1'b0;
            ecf_r        <= 1'b0;
            cps_r        <= CPS_DIV12;
            ofs_r        <= OFS_RESET;
            upd_r        <= UPD_RESET;
            cnt_r        <= CNT_RESET;
            O_SFR_RDATA  <= 8'h00;
            O_IRQ        <= 1'b0;
            O_WDT_RESET  <= 1'b0;
            O_WDT_ACTIVE <= 1'b1;
            O_COUNT      <= CNT_RESET;
        end else begin
            cf_r         <= cf_nxt;
            cr_r         <= cr_nxt;
            ccf_r        <= ccf_nxt;
            idle_suspend_select_r       <= idle_suspend_select_nxt;
            watchdog_enable_bit_r       <= watchdog_enable_bit_nxt;
            lock_r       <= lock_nxt;
            ecf_r        <= ecf_nxt;
            cps_r        <= cps_nxt;
            ofs_r        <= ofs_nxt;
            upd_r        <= upd_nxt;
            cnt_r        <= cnt_nxt;
            O_SFR_RDATA  <= rdata_nxt;
            O_IRQ        <= irq_nxt;
            O_WDT_RESET  <= wrst_nxt;
            O_WDT_ACTIVE <= act_nxt;
            O_COUNT      <= cnt_nxt;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_mode_write;
        wr_hit(I_SFR_ADDR, ADDR_MODE);
    endsequence
    sequence s_expire;
        wd_en && low_ovf && (upd_r == cnt_hi) && !O_WDT_RESET;
    endsequence

    a_reset_defaults: assert property ($past(I_RESET) |->
        O_WDT_ACTIVE && cps_r == CPS_DIV12 && cnt_r[7:0] == 8'h00 && ofs_r == 8'h00)
        else $error("reset defaults wrong");
    a_frozen_setup: assert property ((wd_en ##0 s_mode_write) |=>
        cps_r == $past(cps_r) && idle_suspend_select_r == $past(idle_suspend_select_r))
        else $error("timebase or idle choice changed while watchdog on");
    a_either_enables: assert property ((watchdog_enable_bit_r || lock_r) |-> O_WDT_ACTIVE)
        else $error("watchdog not shown active");
    a_lock_holds: assert property (lock_r |=> lock_r && O_WDT_ACTIVE)
        else $error("locked watchdog was disabled");
    a_unlock_disable: assert property ((!lock_r ##0 s_mode_write
        ##0 (!I_SFR_WDATA[MODE_WATCHDOG_ENABLE_BIT_BIT] && !I_SFR_WDATA[MODE_LOCK_BIT])) |=> !O_WDT_ACTIVE)
        else $error("unlocked disable ignored");
    a_wrap_flag: assert property (wrap |=> cf_r && O_COUNT == 16'h0000)
        else $error("overflow flag missing on wrap");
    a_ovf_irq: assert property ((cf_r && ecf_r) |=> O_IRQ)
        else $error("overflow interrupt missing");
    a_run_stopped: assert property ((!cr_r && !wd_en && !I_SFR_WR) |=>
        O_COUNT == $past(O_COUNT))
        else $error("stopped counter moved");
    a_match_sets: assert property ((I_MATCH_EVT != 6'h00) |=>
        (ccf_r & $past(I_MATCH_EVT)) == $past(I_MATCH_EVT))
        else $error("match flag not set");
    a_match_irq: assert property ((ccf_r & I_MATCH_IE) != 6'h00 |=> O_IRQ)
        else $error("match interrupt missing");
    a_flags_sticky: assert property ((!I_SFR_WR && !I_BIT_WR) |=>
        (ccf_r & $past(ccf_r)) == $past(ccf_r) && (cf_r || !$past(cf_r)))
        else $error("flag cleared by hardware");
    a_update_load: assert property (wr_hit(I_SFR_ADDR, ADDR_M5_UPD) |=>
        upd_r == 8'($past(cnt_hi) + $past(ofs_r)))
        else $error("update byte load wrong");
    // the reset controller answers our own pulse with a reset in that same cycle,
    // so these checks must stay armed through the pulse
    a_expire_reset: assert property (disable iff (I_RESET && !O_WDT_RESET)
        s_expire |=> O_WDT_RESET)
        else $error("watchdog expiry did not reset");
    a_force_reset: assert property (disable iff (I_RESET && !O_WDT_RESET)
        (wd_en && m5_one_wr && !O_WDT_RESET) |=> O_WDT_RESET)
        else $error("forced reset missing");
    a_single_pulse: assert property (disable iff (I_RESET && !O_WDT_RESET)
        O_WDT_RESET |=> !O_WDT_RESET)
        else $error("watchdog reset longer than one cycle");
endmodule // counter_array_watchdog

// [tb/counter_array_watchdog_test.sv]
// self-checking bench for the counter array watchdog and control block
`timescale 1ns/100ps
module counter_array_watchdog_test
    import wdt_ctrl_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdat;
        logic [7:0] expv;
    } row_t;

    logic        I_CLK;
    logic        I_RESET;
    logic        rst_tb;
    logic [7:0]  I_SFR_ADDR;
    logic        I_SFR_WR;
    logic        I_SFR_RD;
    logic [7:0]  I_SFR_WDATA;
    logic        I_BIT_WR;
    logic [2:0]  I_BIT_IDX;
    logic        I_BIT_VAL;
    logic        I_IDLE;
    logic [5:0]  I_MATCH_EVT;
    logic [5:0]  I_MATCH_IE;
    logic [7:0]  O_SFR_RDATA;
    logic [15:0] O_COUNT;
    logic        O_IRQ;
    logic        O_WDT_RESET;
    logic        O_WDT_ACTIVE;
    logic [15:0] held;
    int          mismatches;
    int          checks_done;

    // byte writes and read-back while the watchdog is off; last row is unmapped
    row_t rows [8] = '{
        '{ADDR_MODE,   8'h82, 8'h82}, '{ADDR_M5_OFS, 8'h37, 8'h37},
        '{ADDR_CNT_LO, 8'h5A, 8'h5A}, '{ADDR_CNT_HI, 8'hA5, 8'hA5},
        '{ADDR_CTRL,   8'h3F, 8'h3F}, '{ADDR_CTRL,   8'h00, 8'h00},
        '{ADDR_MODE,   8'h00, 8'h00}, '{8'h33,       8'hFF, 8'h00}};

    // the reset controller turns a watchdog pulse into one reset edge
    assign I_RESET = rst_tb | O_WDT_RESET;

    counter_array_watchdog #(.SLOW_DIV(12)) u_dut (
        .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SFR_ADDR(I_SFR_ADDR),
        .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .I_SFR_WDATA(I_SFR_WDATA),
        .I_BIT_WR(I_BIT_WR), .I_BIT_IDX(I_BIT_IDX), .I_BIT_VAL(I_BIT_VAL),
        .I_IDLE(I_IDLE), .I_T0_OVF(1'b0), .I_ECI(1'b0), .I_EXT_CLK(1'b0),
        .I_MATCH_EVT(I_MATCH_EVT), .I_MATCH_IE(I_MATCH_IE),
        .O_SFR_RDATA(O_SFR_RDATA), .O_COUNT(O_COUNT), .O_IRQ(O_IRQ),
        .O_WDT_RESET(O_WDT_RESET), .O_WDT_ACTIVE(O_WDT_ACTIVE));

    // 20 MHz system clock
    initial begin
        I_CLK = 1'b0;
        forever #25 I_CLK = ~I_CLK;
    end

    // every task starts and ends 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge I_CLK);
        #1;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] expv);
        checks_done++;
        if (got !== expv) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, expv);
        end
    endtask

    task automatic chk_bit(input logic got, input logic expv);
        checks_done++;
        if (got !== expv) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, expv);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        I_SFR_ADDR  = addr;
        I_SFR_WDATA = data;
        I_SFR_WR    = 1'b1;
        tick(1);
        I_SFR_WR    = 1'b0;
        tick(1);
    endtask

    task automatic bw(input int idx, input logic val);
        I_BIT_IDX = 3'(idx);
        I_BIT_VAL = val;
        I_BIT_WR  = 1'b1;
        tick(1);
        I_BIT_WR  = 1'b0;
    endtask

    // read data holds until the next read, so sample one full cycle later
    task automatic rd(input logic [7:0] addr, input logic [7:0] expv);
        I_SFR_ADDR = addr;
        I_SFR_RD   = 1'b1;
        tick(1);
        I_SFR_RD   = 1'b0;
        tick(1);
        chk_val({8'h00, O_SFR_RDATA}, {8'h00, expv});
    endtask

    // bounded wait for the reset pulse; it must land inside lo..hi cycles
    task automatic wait_wdt(input int lo, input int hi);
        int n;
        n = 0;
        while (O_WDT_RESET !== 1'b1 && n <= hi) begin
            tick(1);
            n++;
        end
        chk_bit(n >= lo && n <= hi, 1'b1);
        if (n > hi) begin
            close_out();
        end
        tick(1);
        chk_bit(O_WDT_RESET, 1'b0);
    endtask

    task automatic close_out();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        mismatches = 0;
        checks_done = 0;
        rst_tb = 1'b1;
        I_SFR_ADDR = 8'h00;
        I_SFR_WR = 1'b0;
        I_SFR_RD = 1'b0;
        I_SFR_WDATA = 8'h00;
        I_BIT_WR = 1'b0;
        I_BIT_IDX = 3'h0;
        I_BIT_VAL = 1'b0;
        I_IDLE = 1'b0;
        I_MATCH_EVT = 6'h00;
        I_MATCH_IE = 6'h00;
        tick(6);
        rst_tb = 1'b0;
        // untouched after reset: 256 steps of 12 clocks, then one pulse
        wait_wdt(3068, 3085);
        rd(ADDR_CNT_LO, 8'h00);
        rd(ADDR_M5_OFS, 8'h00);
        rd(ADDR_MODE, 8'h40);
        rd(ADDR_CTRL, 8'h00);
        chk_bit(O_WDT_ACTIVE, 1'b1);
        wr(ADDR_MODE, 8'h00);
        chk_bit(O_WDT_ACTIVE, 1'b0);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdat);
            rd(rows[i].addr, rows[i].expv);
        end
        // each module flag sets, raises the interrupt and sticks until cleared
        I_MATCH_IE = 6'h3F;
        for (int m = 0; m < NUM_MODULES; m++) begin
            I_MATCH_EVT = 6'(1 << m);
            tick(1);
            I_MATCH_EVT = 6'h00;
            tick(4);
            rd(ADDR_CTRL, 8'(1 << m));
            chk_bit(O_IRQ, 1'b1);
            bw(m, 1'b0);
            tick(2);
            chk_bit(O_IRQ, 1'b0);
        end
        // wrap 0xFFFF to 0x0000 on the system clock timebase with overflow irq on
        wr(ADDR_MODE, 8'h09);
        wr(ADDR_CNT_LO, 8'hFE);
        wr(ADDR_CNT_HI, 8'hFF);
        bw(CTRL_RUN_BIT, 1'b1);
        tick(8);
        bw(CTRL_RUN_BIT, 1'b0);
        tick(2);
        held = O_COUNT;
        tick(5);
        chk_val(O_COUNT, held);
        chk_bit(held < 16'h0010, 1'b1);
        rd(ADDR_CTRL, 8'h80);
        chk_bit(O_IRQ, 1'b1);
        bw(CTRL_OVF_BIT, 1'b0);
        tick(2);
        chk_bit(O_IRQ, 1'b0);
        // idle suspend holds the counter even with the run bit set
        wr(ADDR_MODE, 8'h89);
        I_IDLE = 1'b1;
        bw(CTRL_RUN_BIT, 1'b1);
        tick(4);
        bw(CTRL_RUN_BIT, 1'b0);
        I_IDLE = 1'b0;
        chk_val(O_COUNT, held);
        // enabled: timebase and idle choice must not move
        wr(ADDR_MODE, 8'h49);
        chk_bit(O_WDT_ACTIVE, 1'b1);
        wr(ADDR_MODE, 8'hC3);
        rd(ADDR_MODE, 8'h49);
        wr(ADDR_MODE, 8'h09);
        chk_bit(O_WDT_ACTIVE, 1'b0);
        // lock alone enables, and a write of zero then cannot clear the lock or disable the watchdog
        wr(ADDR_MODE, 8'h20);
        chk_bit(O_WDT_ACTIVE, 1'b1);
        wr(ADDR_MODE, 8'h00);
        tick(2);
        chk_bit(O_WDT_ACTIVE, 1'b1);
        rd(ADDR_MODE, 8'h20);
        bw(CTRL_M5_BIT, 1'b1);
        wait_wdt(0, 3);
        rd(ADDR_MODE, 8'h40);
        // full configuration order, system clock timebase, offset of two high-byte steps
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_CNT_HI, 8'h00);
        wr(ADDR_MODE, 8'h08);
        wr(ADDR_M5_OFS, 8'h02);
        wr(ADDR_MODE, 8'h48);
        wr(ADDR_M5_UPD, 8'h55);
        rd(ADDR_M5_UPD, 8'h02);
        wait_wdt(750, 775);
        close_out();
    end
endmodule // counter_array_watchdog_test
